// ---- shared/pwmfb_pkg.sv ----
// Purpose: Shared constants and types for the PWM fault/blanking slice
// Assumes: 16-bit register port, 25 MHz system clock
// Notes:   Register offsets are word indices on the plain register port
package pwmfb_pkg;
	localparam logic [3:0]  ADDR_PERIOD   = 4'h0;
	localparam logic [3:0]  ADDR_SEVT     = 4'h1;
	localparam logic [3:0]  ADDR_DUTY     = 4'h2;
	localparam logic [3:0]  ADDR_GENCTL   = 4'h3;
	localparam logic [3:0]  ADDR_FLTCTL   = 4'h4;
	localparam logic [3:0]  ADDR_BLANK    = 4'h5;
	localparam logic [3:0]  ADDR_STATUS   = 4'h6;
	localparam logic [3:0]  ADDR_PINS     = 4'h7;
	localparam logic [3:0]  ADDR_DEAD     = 4'h8;
	localparam logic [15:0] RST_VALUE     = 16'h0000;
	localparam logic [15:0] LOW3_MASK     = 16'hFFF8;
	localparam int          NUM_FLT_PINS  = 12;
	// GENCTL bits
	localparam int GC_ENABLE   = 0;
	localparam int GC_CURRST   = 1;
	localparam int GC_FIEN     = 2;
	localparam int GC_CLR      = 3;
	// FLTCTL bits
	localparam int FC_SRC_LSB  = 0;
	localparam int FC_POL      = 4;
	localparam int FC_FLTLEB   = 5;
	localparam int FC_LIMLEB   = 6;
	localparam int FC_LIM_LSB  = 8;
	// Blanking field sits in bits 9:3
	localparam int BL_LSB      = 3;
	// Blanking base 120 MHz against a 25 MHz clock: ticks scaled by 25/120
	localparam int          CLK_MHZ       = 25;
	localparam int          LEB_BASE_MHZ  = 120;
	localparam int          LEB_OFFSET_PS = 8400;
	localparam int          CLK_PERIOD_PS = 40000;
	localparam logic [9:0]  LEB_OFFSET_CYC =
		10'((LEB_OFFSET_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	typedef struct packed {
		logic [1:0] sync;
		logic       reset_seen;
	} pwmfb_sync_t;
endpackage : pwmfb_pkg

// ---- rtl/pwmfb_top.sv ----
// Purpose: PWM generator slice with current reset, blanking and fault logic
// Assumes: Register port strobes one cycle; inputs synchronous except ext reset
// Notes:   Fault override path is combinational into a registered output stage
`timescale 1ns/100ps
module pwmfb_top (
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	input  wire logic [3:0]  addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	input  wire logic [11:0] fault_input_pin_i,
	input  wire logic        ext_reset_i,
	output logic      [15:0] rdata_o,
	output logic             pwm_h_o,
	output logic             pwm_l_o,
	output logic             fault_irq_o,
	output logic             special_event_o,
	output logic      [11:0] pin_free_o
);
	typedef struct packed {
		logic [15:0] period;
		logic [15:0] sevt;
		logic [15:0] duty;
		logic [15:0] genctl;
		logic [15:0] fltctl;
		logic [15:0] blank;
		logic [15:0] dead;
		logic [15:0] tmr;
		logic [9:0]  leb_cnt;
		logic        pwm;
		logic        pwm_h;
		logic        pwm_l;
		logic        irq_latch;
		logic        flt_end_prev;
		logic        sevt_pulse;
		logic [1:0]  ext_sync;
		logic        ext_prev;
		logic [15:0] rdata;
		logic [11:0] pin_free;
	} pwmfb_state_t;

	pwmfb_state_t s_q;
	pwmfb_state_t s_d;

	logic       flt_raw;
	logic       flt_sel;
	logic       lim_sel;
	logic       blanking;
	logic       flt_det;
	logic       lim_det;
	logic       ext_rise;
	logic [9:0] leb_load;
	logic       pwm_next;
	logic       wrap;
	logic [15:0] status_word;

	// Source select; codes above eleven pick nothing
	always_comb begin
		flt_raw = 1'b0;
		lim_sel = 1'b0;
		if (s_q.fltctl[pwmfb_pkg::FC_SRC_LSB+:4] < 4'(pwmfb_pkg::NUM_FLT_PINS)) begin
			flt_raw = fault_input_pin_i[s_q.fltctl[pwmfb_pkg::FC_SRC_LSB+:4]];
		end
		if (s_q.fltctl[pwmfb_pkg::FC_LIM_LSB+:4] < 4'(pwmfb_pkg::NUM_FLT_PINS)) begin
			lim_sel = fault_input_pin_i[s_q.fltctl[pwmfb_pkg::FC_LIM_LSB+:4]];
		end
	end

	assign flt_sel  = flt_raw ^ s_q.fltctl[pwmfb_pkg::FC_POL];
	assign blanking = (s_q.leb_cnt != 10'h000);
	// Held through the cycle edge with dead time set: no masking
	assign flt_det  = flt_sel & (~(blanking & s_q.fltctl[pwmfb_pkg::FC_FLTLEB])
		| (s_q.flt_end_prev & (s_q.dead != 16'h0000)));
	assign lim_det  = lim_sel & (~(blanking & s_q.fltctl[pwmfb_pkg::FC_LIMLEB])
		| (s_q.flt_end_prev & (s_q.dead != 16'h0000)));
	// Only second stage is looked at
	assign ext_rise = s_q.ext_sync[1] & ~s_q.ext_prev;
	assign wrap     = (s_q.tmr >= s_q.period);
	// Field+1 base ticks scaled to 25 MHz, plus fixed offset cycles
	assign leb_load = 10'(((32'(s_q.blank[9:3]) + 32'h1) * pwmfb_pkg::CLK_MHZ
		+ pwmfb_pkg::LEB_BASE_MHZ - 1) / pwmfb_pkg::LEB_BASE_MHZ)
		+ pwmfb_pkg::LEB_OFFSET_CYC;
	assign status_word = {13'h0000, s_q.pwm, lim_sel,
		s_q.genctl[pwmfb_pkg::GC_FIEN] ? s_q.irq_latch : flt_sel};

	always_comb begin
		s_d = s_q;
		s_d.sevt_pulse = 1'b0;
		s_d.ext_sync   = {s_q.ext_sync[0], ext_reset_i};
		s_d.ext_prev   = s_q.ext_sync[1];
		s_d.rdata      = 16'h0000;
		if (s_q.genctl[pwmfb_pkg::GC_ENABLE]) begin
			// Current reset lets the external edge restart the period
			if (wrap || (s_q.genctl[pwmfb_pkg::GC_CURRST] && ext_rise && !s_q.pwm)) begin
				s_d.tmr = 16'h0000;
			end else begin
				s_d.tmr = s_q.tmr + 16'h0008;
			end
			if ((s_q.tmr & pwmfb_pkg::LOW3_MASK) == s_q.sevt) begin
				s_d.sevt_pulse = 1'b1;
			end
			s_d.flt_end_prev = wrap & flt_sel | (s_q.flt_end_prev & flt_sel & (s_q.tmr == 16'h0000));
		end else begin
			s_d.tmr = 16'h0000;
			s_d.flt_end_prev = 1'b0;
		end
		pwm_next = s_q.genctl[pwmfb_pkg::GC_ENABLE] && (s_d.tmr < s_q.duty) && !lim_det;
		s_d.pwm = pwm_next;
		if (pwm_next != s_q.pwm) begin
			s_d.leb_cnt = leb_load;
		end else if (blanking) begin
			s_d.leb_cnt = s_q.leb_cnt - 10'h001;
		end
		// Fault forces both outputs low; complementary kept in current reset
		s_d.pwm_h = pwm_next & ~flt_det;
		s_d.pwm_l = ~pwm_next & ~flt_det & s_q.genctl[pwmfb_pkg::GC_ENABLE];
		if (flt_det && s_q.genctl[pwmfb_pkg::GC_FIEN]) begin
			s_d.irq_latch = 1'b1;
		end else if (wr_i && addr_i == pwmfb_pkg::ADDR_GENCTL && wdata_i[pwmfb_pkg::GC_CLR]) begin
			s_d.irq_latch = 1'b0;
		end
		s_d.pin_free = '1;
		s_d.pin_free[s_q.fltctl[3:0] < 4'hC ? s_q.fltctl[3:0] : 4'h0] =
			~(s_q.genctl[pwmfb_pkg::GC_ENABLE] && s_q.fltctl[3:0] < 4'hC);
		if (wr_i) begin
			case (addr_i)
				pwmfb_pkg::ADDR_PERIOD: s_d.period = wdata_i & pwmfb_pkg::LOW3_MASK;
				pwmfb_pkg::ADDR_SEVT:   s_d.sevt   = wdata_i & pwmfb_pkg::LOW3_MASK;
				pwmfb_pkg::ADDR_DUTY:   s_d.duty   = wdata_i;
				pwmfb_pkg::ADDR_GENCTL: s_d.genctl = {12'h000, 1'b0, wdata_i[2:0]};
				pwmfb_pkg::ADDR_FLTCTL: s_d.fltctl = wdata_i;
				pwmfb_pkg::ADDR_BLANK:  s_d.blank  = {6'h00, wdata_i[9:3], 3'h0};
				pwmfb_pkg::ADDR_DEAD:   s_d.dead   = wdata_i;
				default: ;
			endcase
		end
		if (rd_i) begin
			case (addr_i)
				pwmfb_pkg::ADDR_PERIOD: s_d.rdata = s_q.period;
				pwmfb_pkg::ADDR_SEVT:   s_d.rdata = s_q.sevt;
				pwmfb_pkg::ADDR_DUTY:   s_d.rdata = s_q.duty;
				pwmfb_pkg::ADDR_GENCTL: s_d.rdata = s_q.genctl;
				pwmfb_pkg::ADDR_FLTCTL: s_d.rdata = s_q.fltctl;
				pwmfb_pkg::ADDR_BLANK:  s_d.rdata = s_q.blank;
				pwmfb_pkg::ADDR_STATUS: s_d.rdata = status_word;
				pwmfb_pkg::ADDR_PINS:   s_d.rdata = {4'h0, fault_input_pin_i};
				pwmfb_pkg::ADDR_DEAD:   s_d.rdata = s_q.dead;
				default:                s_d.rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_q <= '0;
			s_q.pin_free <= 12'hFFF;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata_o         = s_q.rdata;
	assign pwm_h_o         = s_q.pwm_h;
	assign pwm_l_o         = s_q.pwm_l;
	assign fault_irq_o     = s_q.irq_latch;
	assign special_event_o = s_q.sevt_pulse;
	assign pin_free_o      = s_q.pin_free;

	chk_sevt_low_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		s_q.sevt[2:0] == 3'h0) else $error("compare low bits set");
	chk_period_low_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		s_q.period[2:0] == 3'h0) else $error("period low bits set");
	chk_ext_reset_tmr: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(s_q.genctl[1:0] == 2'b11 && ext_rise && !s_q.pwm) |=> s_q.tmr == 16'h0000)
		else $error("ext reset ignored");
	chk_irq_needs_en: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$rose(fault_irq_o) |-> $past(s_q.genctl[pwmfb_pkg::GC_FIEN]))
		else $error("irq without enable");
	chk_fault_override: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		flt_det |=> !pwm_h_o && !pwm_l_o) else $error("fault not overriding");
	chk_polarity_inv: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		flt_sel == (flt_raw ^ s_q.fltctl[4])) else $error("polarity wrong");
	chk_leb_restart: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		($changed(s_q.pwm)) |-> s_q.leb_cnt == $past(leb_load))
		else $error("blanking not restarted");
	chk_outputs_exclusive: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!(pwm_h_o && pwm_l_o)) else $error("both outputs high");
	chk_sync_two_stage: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		s_q.ext_sync[1] == $past(ext_reset_i, 2)) else $error("sync depth wrong");

	chk_status_live: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!s_q.genctl[pwmfb_pkg::GC_FIEN] |-> status_word[0] == flt_sel)
		else $error("status not live level");

	chk_status_latch: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		s_q.genctl[pwmfb_pkg::GC_FIEN] |-> status_word[0] == s_q.irq_latch)
		else $error("status not latch");

	chk_blank_bypass: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(flt_sel && s_q.flt_end_prev && s_q.dead != 16'h0000) |-> flt_det)
		else $error("persistent fault masked");

	chk_fault_blank_mask: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(blanking && s_q.fltctl[pwmfb_pkg::FC_FLTLEB] && !s_q.flt_end_prev) |-> !flt_det)
		else $error("fault seen in blanking");

	chk_limit_blank_mask: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(blanking && s_q.fltctl[pwmfb_pkg::FC_LIMLEB] && !s_q.flt_end_prev) |-> !lim_det)
		else $error("limit seen in blanking");

	chk_fault_unmasked: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(flt_sel && !s_q.fltctl[pwmfb_pkg::FC_FLTLEB]) |-> flt_det)
		else $error("fault masked without enable");

	chk_leb_load_floor: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		leb_load >= pwmfb_pkg::LEB_OFFSET_CYC + 10'h001)
		else $error("blanking shorter than offset");

	chk_leb_load_ceil: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		leb_load <= 10'h020)
		else $error("blanking load too long");

	chk_leb_count_down: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(blanking && pwm_next == s_q.pwm) |=> s_q.leb_cnt == $past(s_q.leb_cnt) - 10'h001)
		else $error("blanking counter stalled");

	chk_src_none: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(s_q.fltctl[3:0] >= 4'hC) |-> !flt_raw)
		else $error("unused source code selects pin");

	chk_limit_cuts: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		lim_det |=> !pwm_h_o)
		else $error("limit did not cut output");

	chk_comp_low: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(s_q.genctl[pwmfb_pkg::GC_ENABLE] && !pwm_next && !flt_det) |=> pwm_l_o)
		else $error("complementary output missing");

	chk_pin_free_used: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(s_q.genctl[pwmfb_pkg::GC_ENABLE] && s_q.fltctl[3:0] == 4'h3) |=> !pin_free_o[3])
		else $error("used pin shown free");

	chk_pin_free_idle: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!s_q.genctl[pwmfb_pkg::GC_ENABLE] |=> pin_free_o == 12'hFFF)
		else $error("pin held while disabled");

	chk_irq_sticky: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(fault_irq_o && !(wr_i && addr_i == pwmfb_pkg::ADDR_GENCTL)) |=> fault_irq_o)
		else $error("irq latch dropped");

	chk_rdata_pins: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(rd_i && addr_i == pwmfb_pkg::ADDR_PINS) |=> rdata_o == {4'h0, $past(fault_input_pin_i)})
		else $error("pin levels not readable");

	chk_sevt_match: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(s_q.genctl[0] && (s_q.tmr & pwmfb_pkg::LOW3_MASK) == s_q.sevt) |=> special_event_o)
		else $error("special event missed");

	chk_ext_sync_used: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!s_q.ext_sync[1] |-> !ext_rise)
		else $error("edge taken from first stage");

	// Period zero keeps the timer at zero, so the pulse may repeat there
	chk_sevt_single: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(special_event_o && s_q.period != 16'h0000) |=> !special_event_o)
		else $error("special event too long");

	chk_disabled_quiet: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!s_q.genctl[pwmfb_pkg::GC_ENABLE] |=> !pwm_h_o && !pwm_l_o)
		else $error("outputs active while disabled");

	chk_rdata_idle: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!rd_i |=> rdata_o == 16'h0000)
		else $error("read data without strobe");

	chk_lim_none: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(s_q.fltctl[11:8] >= 4'hC) |-> !lim_sel)
		else $error("unused limit code selects pin");

	cov_fault_irq: cover property (@(posedge clk_i) $rose(fault_irq_o));
	cov_blank_mask: cover property (@(posedge clk_i) blanking && flt_sel);
	cov_limit_cut: cover property (@(posedge clk_i) lim_det && s_q.pwm);
	cov_ext_reset: cover property (@(posedge clk_i) ext_rise && s_q.genctl[1]);
	cov_special_evt: cover property (@(posedge clk_i) special_event_o);
endmodule : pwmfb_top

// ---- dv/pwmfb_sense_model.sv ----
// Purpose: Current sensing partner that resets the time base
// Assumes: Inductor has emptied DLY cycles after the on-time ends
// Notes:   Pulse lasts two cycles so the synchroniser cannot miss it
`timescale 1ns/100ps
module pwmfb_sense_model #(
	parameter int DLY = 5
) (
	input  wire logic clk_i,
	input  wire logic pwm_h_i,
	input  wire logic arm_i,
	output logic      ext_reset_o = 1'b0
);
	int   cnt  = 0;
	logic prev = 1'b0;
	always @(posedge clk_i) begin
		prev <= pwm_h_i;
		if (arm_i && prev && !pwm_h_i) begin
			cnt <= DLY;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end
		ext_reset_o <= arm_i && (cnt == 1 || cnt == 2);
	end
endmodule : pwmfb_sense_model

// ---- dv/pwmfb_top_bench.sv ----
// Purpose: Self-checking bench for the PWM fault and current reset slice
// Assumes: Fault pins settle in the status within four cycles
// Notes:   Blanking timing is left to the in-design checks
`timescale 1ns/100ps
module pwmfb_top_bench;
	logic        clk   = 1'b0;
	logic        rst_b = 1'b0;
	logic [3:0]  addr  = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic        wr    = 1'b0;
	logic        rd    = 1'b0;
	logic [11:0] pins  = 12'h000;
	logic        arm   = 1'b0;
	logic [15:0] rdata;
	logic        pwm_h;
	logic        pwm_l;
	logic        irq;
	logic        ext_rst;
	logic        sevt;
	logic [11:0] pin_free;
	int          mismatches = 0;
	int          compares   = 0;
	int          cycles     = 0;
	pwmfb_top dut (.clk_i(clk), .rst_b_i(rst_b), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
		.rd_i(rd), .fault_input_pin_i(pins), .ext_reset_i(ext_rst), .rdata_o(rdata),
		.pwm_h_o(pwm_h), .pwm_l_o(pwm_l), .fault_irq_o(irq), .special_event_o(sevt),
		.pin_free_o(pin_free));
	pwmfb_sense_model #(.DLY(5)) sense (.clk_i(clk), .pwm_h_i(pwm_h), .arm_i(arm),
		.ext_reset_o(ext_rst));
	initial begin
		forever #20 clk = ~clk;
	end
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [3:0] a, input logic [15:0] e, input string what,
		input logic [15:0] m = 16'hFFFF);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(what, e, rdata & m);
	endtask : rd_reg
	task automatic settle();
		repeat (4) @(posedge clk);
	endtask : settle
	task automatic wait_lvl(input logic v);
		repeat (700) begin
			@(posedge clk);
			#1;
			if (pwm_h === v) return;
		end
	endtask : wait_lvl
	task automatic t_regs();
		chk("pin_free", 16'h0FFF, {4'h0, pin_free});
		rd_reg(pwmfb_pkg::ADDR_SEVT, 16'h0000, "sevt reset");
		wr_reg(pwmfb_pkg::ADDR_SEVT, 16'hFFFF);
		rd_reg(pwmfb_pkg::ADDR_SEVT, 16'hFFF8, "sevt");
		wr_reg(pwmfb_pkg::ADDR_PERIOD, 16'hFFFF);
		rd_reg(pwmfb_pkg::ADDR_PERIOD, 16'hFFF8, "period");
		wr_reg(4'hC, 16'h1234);
		rd_reg(4'hC, 16'h0000, "unmapped");
	endtask : t_regs
	task automatic t_fault();
		wr_reg(pwmfb_pkg::ADDR_FLTCTL, 16'h0F03);
		pins <= 12'h008;
		settle();
		rd_reg(pwmfb_pkg::ADDR_STATUS, 16'h0001, "live", 16'h0001);
		rd_reg(pwmfb_pkg::ADDR_PINS, 16'h0008, "pins");
		chk("pin_free", 16'h0FFF, {4'h0, pin_free});
		wr_reg(pwmfb_pkg::ADDR_FLTCTL, 16'h0F13);
		settle();
		rd_reg(pwmfb_pkg::ADDR_STATUS, 16'h0000, "inverted", 16'h0001);
		pins <= 12'h000;
		settle();
		rd_reg(pwmfb_pkg::ADDR_STATUS, 16'h0001, "inverted low", 16'h0001);
	endtask : t_fault
	task automatic t_irq();
		wr_reg(pwmfb_pkg::ADDR_FLTCTL, 16'h0F03);
		wr_reg(pwmfb_pkg::ADDR_PERIOD, 16'h0FF8);
		wr_reg(pwmfb_pkg::ADDR_DUTY, 16'h0040);
		wr_reg(pwmfb_pkg::ADDR_GENCTL, 16'h0001);
		pins <= 12'h008;
		settle();
		chk("irq off", 16'h0000, {15'h0, irq});
		chk("pin_free used", 16'h0FF7, {4'h0, pin_free});
		chk("outputs", 16'h0000, {14'h0, pwm_h, pwm_l});
		wr_reg(pwmfb_pkg::ADDR_GENCTL, 16'h0005);
		settle();
		chk("irq on", 16'h0001, {15'h0, irq});
		pins <= 12'h000;
		settle();
		rd_reg(pwmfb_pkg::ADDR_STATUS, 16'h0001, "latched", 16'h0001);
		wr_reg(pwmfb_pkg::ADDR_GENCTL, 16'h000D);
		settle();
		chk("irq clear", 16'h0000, {15'h0, irq});
	endtask : t_irq
	task automatic t_sevt();
		int n;
		n = 0;
		wr_reg(pwmfb_pkg::ADDR_SEVT, 16'h0020);
		while (sevt !== 1'b1 && n < 600) begin
			n++;
			@(posedge clk);
			#1;
		end
		chk("sevt pulse", 16'h0001, {15'h0, sevt});
		@(posedge clk);
		#1;
		chk("sevt width", 16'h0000, {15'h0, sevt});
	endtask : t_sevt
	task automatic t_curr();
		int hi;
		int per;
		hi  = 0;
		per = 0;
		wr_reg(pwmfb_pkg::ADDR_FLTCTL, 16'h0F0F);
		wr_reg(pwmfb_pkg::ADDR_GENCTL, 16'h0003);
		arm <= 1'b1;
		wait_lvl(1'b1);
		wait_lvl(1'b0);
		wait_lvl(1'b1);
		chk("low side", 16'h0000, {15'h0, pwm_l});
		while (pwm_h === 1'b1 && hi < 700) begin
			hi++;
			@(posedge clk);
			#1;
		end
		while (pwm_h === 1'b0 && per < 700) begin
			per++;
			@(posedge clk);
			#1;
		end
		chk("on time", 16'd8, hi[15:0]);
		chk("short period", 16'h0001, {15'h0, (hi + per) < 511});
	endtask : t_curr
	task automatic complete_run();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : complete_run
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			complete_run();
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		t_regs();
		t_fault();
		t_irq();
		t_sevt();
		t_curr();
		complete_run();
	end
endmodule : pwmfb_top_bench
